// file: hdl/dcevt_pkg.sv
// dcevt_pkg: register map, field positions and state types of the channel event block
// assumes a 32-bit register port with one-cycle strobes
package dcevt_pkg;
  // ========================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_EVENT_CTRL = 8'h00;
  localparam logic [7:0] OFS_INT_CTRL = 8'h04;
  localparam logic [7:0] OFS_SRC_START = 8'h08;
  localparam logic [7:0] OFS_CHAN_CTRL = 8'h0c;
  localparam logic [7:0] OFS_SIZES = 8'h10;
  // ========================================
  // event control fields
  localparam int ABORT_SEL_LSB = 16;
  localparam int START_SEL_LSB = 8;
  localparam int FORCE_BIT = 7;
  localparam int SWABORT_BIT = 6;
  localparam int PATTERN_ABORT_ENABLE_BIT = 5;
  localparam int START_ON_REQUEST_ENABLE_BIT = 4;
  localparam int ABORT_ON_REQUEST_ENABLE_BIT = 3;
  localparam logic [7:0] SEL_RESET = 8'hff;
  // ========================================
  // interrupt control fields
  localparam int IE_LSB = 16;
  localparam int FLAG_SRC_DONE = 7;
  localparam int FLAG_SRC_HALF = 6;
  localparam int FLAG_DST_DONE = 5;
  localparam int FLAG_DST_HALF = 4;
  localparam int FLAG_BLOCK = 3;
  localparam int FLAG_CELL = 2;
  localparam int FLAG_ABORT = 1;
  localparam int FLAG_ADDR_ERR = 0;
  // ========================================
  // channel control and size fields
  localparam int CHAN_ON_BIT = 7;
  localparam int AUTO_REEN_BIT = 4;
  localparam int BUSY_BIT = 15;
  localparam int DST_SIZE_LSB = 16;
  localparam logic [16:0] SIZE_ZERO_BYTES = 17'h10000;

  typedef enum logic [0:0] {DCEVT_IDLE, DCEVT_RUN} dcevt_state_type;

  // progress reported by the data mover
  typedef struct packed {
    logic [15:0] src_ptr;
    logic [15:0] dst_ptr;
    logic src_step;
    logic dst_step;
    logic cell_done;
    logic pattern_match;
    logic addr_error;
  } dcevt_prog_type;

  typedef struct packed {
    dcevt_state_type st;
    logic [7:0] abort_sel;
    logic [7:0] start_sel;
    logic pattern_abort_enable;
    logic start_on_request_enable;
    logic abort_on_request_enable;
    logic [7:0] ie;
    logic [7:0] flags;
    logic [31:0] src_start;
    logic chan_on;
    logic auto_reen;
    logic [15:0] src_size;
    logic [15:0] dst_size;
    logic start_p;
    logic abort_p;
    logic [31:0] rdata;
  } dcevt_state_reg_type;
endpackage

// file: hdl/dcevt_channel.sv
// dcevt_channel: event, abort and interrupt flag logic of one DMA channel
// assumes the data mover reports pointer values and steps on dcevt_prog_type
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
// What this block does
// - abort selector picks irq; abort, set flag
// - start selector picks irq that starts transfer
// - force bit write one starts, reads zero
// - abort bit write one aborts, reads zero
// - pattern enable: match aborts, clears channel
// - start irq ignored unless start enable
// - abort irq ignored unless abort enable
// - unimplemented bits read zero, ignore writes
// - enable bits pair with flags, same order
// - source done when pointer equals size
// - source half when pointer equals half
// - destination done when pointer equals size
// - destination half when pointer equals half
// - block done on larger size or match
// - cell done each cell size moved
// - abort flag when abort irq aborts
// - address error flag on bad address
// - block done clears channel unless auto
// - size zero means 65536 bytes
module dcevt_channel #(
  parameter int NUM_IRQ = 256
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // register port
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  // peripheral interrupt lines
  input wire logic [NUM_IRQ-1:0] IRQ_LINES,
  // data mover side
  input wire dcevt_pkg::dcevt_prog_type PROG,
  output logic START_XFER,
  output logic ABORT_XFER,
  output logic CHAN_ON,
  output logic CHAN_IRQ
);
  dcevt_pkg::dcevt_state_reg_type s_r;
  dcevt_pkg::dcevt_state_reg_type s_nxt;
  logic [16:0] src_bytes;
  logic [16:0] dst_bytes;
  logic [16:0] big_bytes;
  logic [16:0] moved_r;
  logic [16:0] moved_nxt;
  logic start_irq;
  logic abort_irq;
  logic [7:0] ev;
  logic [7:0] pend;

  // ========================================
  // size decode and event detection
  always_comb begin
    src_bytes = (s_r.src_size == 16'h0000) ? dcevt_pkg::SIZE_ZERO_BYTES : {1'b0, s_r.src_size};
    dst_bytes = (s_r.dst_size == 16'h0000) ? dcevt_pkg::SIZE_ZERO_BYTES : {1'b0, s_r.dst_size};
    big_bytes = (src_bytes > dst_bytes) ? src_bytes : dst_bytes;
    start_irq = IRQ_LINES[s_r.start_sel] && s_r.start_on_request_enable;
    abort_irq = IRQ_LINES[s_r.abort_sel] && s_r.abort_on_request_enable;
    ev = 8'h00;
    if (s_r.st == dcevt_pkg::DCEVT_RUN) begin
      ev[dcevt_pkg::FLAG_SRC_DONE] = PROG.src_step && ({1'b0, PROG.src_ptr} == src_bytes);
      ev[dcevt_pkg::FLAG_SRC_HALF] = PROG.src_step && ({1'b0, PROG.src_ptr} == (src_bytes >> 1));
      ev[dcevt_pkg::FLAG_DST_DONE] = PROG.dst_step && ({1'b0, PROG.dst_ptr} == dst_bytes);
      ev[dcevt_pkg::FLAG_DST_HALF] = PROG.dst_step && ({1'b0, PROG.dst_ptr} == (dst_bytes >> 1));
      ev[dcevt_pkg::FLAG_BLOCK] = (PROG.src_step && (moved_r + 17'h00001 == big_bytes))
        || (PROG.pattern_match && s_r.pattern_abort_enable);
      ev[dcevt_pkg::FLAG_CELL] = PROG.cell_done;
      ev[dcevt_pkg::FLAG_ABORT] = abort_irq;
    end
    ev[dcevt_pkg::FLAG_ADDR_ERR] = PROG.addr_error;
  end

  // ========================================
  // next state
  always_comb begin
    s_nxt = s_r;
    moved_nxt = moved_r;
    s_nxt.start_p = 1'b0;
    s_nxt.abort_p = 1'b0;
    s_nxt.rdata = 32'h00000000;
    if (WR) begin
      case (ADDR)
        dcevt_pkg::OFS_EVENT_CTRL: begin
          s_nxt.abort_sel = WDATA[dcevt_pkg::ABORT_SEL_LSB +: 8];
          s_nxt.start_sel = WDATA[dcevt_pkg::START_SEL_LSB +: 8];
          s_nxt.pattern_abort_enable = WDATA[dcevt_pkg::PATTERN_ABORT_ENABLE_BIT];
          s_nxt.start_on_request_enable = WDATA[dcevt_pkg::START_ON_REQUEST_ENABLE_BIT];
          s_nxt.abort_on_request_enable = WDATA[dcevt_pkg::ABORT_ON_REQUEST_ENABLE_BIT];
          s_nxt.start_p = WDATA[dcevt_pkg::FORCE_BIT];
          s_nxt.abort_p = WDATA[dcevt_pkg::SWABORT_BIT];
        end
        dcevt_pkg::OFS_INT_CTRL: begin
          s_nxt.ie = WDATA[dcevt_pkg::IE_LSB +: 8];
          s_nxt.flags = WDATA[7:0];
        end
        dcevt_pkg::OFS_SRC_START: s_nxt.src_start = WDATA;
        dcevt_pkg::OFS_CHAN_CTRL: begin
          s_nxt.chan_on = WDATA[dcevt_pkg::CHAN_ON_BIT];
          s_nxt.auto_reen = WDATA[dcevt_pkg::AUTO_REEN_BIT];
        end
        dcevt_pkg::OFS_SIZES: begin
          s_nxt.src_size = WDATA[15:0];
          s_nxt.dst_size = WDATA[dcevt_pkg::DST_SIZE_LSB +: 16];
        end
        default: begin
        end
      endcase
    end
    if (start_irq) begin
      s_nxt.start_p = 1'b1;
    end
    if (abort_irq) begin
      s_nxt.abort_p = 1'b1;
    end
    // hardware set wins over a same-cycle software clear
    s_nxt.flags = s_nxt.flags | ev;
    case (s_r.st)
      dcevt_pkg::DCEVT_IDLE: begin
        moved_nxt = 17'h00000;
        if (s_r.start_p && s_r.chan_on) begin
          s_nxt.st = dcevt_pkg::DCEVT_RUN;
        end
      end
      dcevt_pkg::DCEVT_RUN: begin
        if (PROG.src_step) begin
          moved_nxt = moved_r + 17'h00001;
        end
        // an abort irq goes through abort_p so the mover sees ABORT_XFER
        if (s_r.abort_p) begin
          s_nxt.st = dcevt_pkg::DCEVT_IDLE;
        end else if (PROG.pattern_match && s_r.pattern_abort_enable) begin
          s_nxt.st = dcevt_pkg::DCEVT_IDLE;
          s_nxt.chan_on = 1'b0;
        end else if (ev[dcevt_pkg::FLAG_BLOCK]) begin
          s_nxt.st = dcevt_pkg::DCEVT_IDLE;
          if (!s_r.auto_reen) begin
            s_nxt.chan_on = 1'b0;
          end
        end
      end
      default: s_nxt.st = dcevt_pkg::DCEVT_IDLE;
    endcase
    if (RD) begin
      case (ADDR)
        dcevt_pkg::OFS_EVENT_CTRL: s_nxt.rdata = {8'h00, s_r.abort_sel, s_r.start_sel, 2'b00,
          s_r.pattern_abort_enable, s_r.start_on_request_enable, s_r.abort_on_request_enable, 3'b000};
        dcevt_pkg::OFS_INT_CTRL: s_nxt.rdata = {8'h00, s_r.ie, 8'h00, s_r.flags};
        dcevt_pkg::OFS_SRC_START: s_nxt.rdata = s_r.src_start;
        dcevt_pkg::OFS_CHAN_CTRL: s_nxt.rdata = {16'h0000, (s_r.st == dcevt_pkg::DCEVT_RUN),
          7'h00, s_r.chan_on, 2'b00, s_r.auto_reen, 4'h0};
        dcevt_pkg::OFS_SIZES: s_nxt.rdata = {s_r.dst_size, s_r.src_size};
        default: s_nxt.rdata = 32'h00000000;
      endcase
    end
  end

  // ========================================
  // state register
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      s_r <= '0;
      s_r.abort_sel <= dcevt_pkg::SEL_RESET;
      s_r.start_sel <= dcevt_pkg::SEL_RESET;
      s_r.st <= dcevt_pkg::DCEVT_IDLE;
      moved_r <= 17'h00000;
    end else begin
      s_r <= s_nxt;
      moved_r <= moved_nxt;
    end
  end

  assign RDATA = s_r.rdata;
  assign START_XFER = (s_r.st == dcevt_pkg::DCEVT_IDLE) && s_r.start_p && s_r.chan_on;
  assign ABORT_XFER = (s_r.st == dcevt_pkg::DCEVT_RUN) && s_r.abort_p;
  assign CHAN_ON = s_r.chan_on;
  assign CHAN_IRQ = |pend;

  // ========================================
  // flag and enable pairing, one lane per status bit
  for (genvar gi = 0; gi < 8; gi++) begin : g_pair
    assign pend[gi] = s_r.flags[gi] & s_r.ie[gi];
    property p_flag_holds;
      @(posedge CLK) disable iff (!RSTN)
        (s_r.flags[gi] && !(WR && ADDR == dcevt_pkg::OFS_INT_CTRL)) |=> s_r.flags[gi];
    endproperty
    a_flag_holds: assert property (p_flag_holds) else $error("flag lost");
  end

  // ========================================
  // assertions
  property p_start_ignored;
    @(posedge CLK) disable iff (!RSTN)
      (!s_r.start_on_request_enable && !WR && IRQ_LINES[s_r.start_sel] && !s_r.start_p) |=> !s_r.start_p;
  endproperty
  a_start_ignored: assert property (p_start_ignored) else $error("start irq not ignored");
  property p_abort_irq;
    @(posedge CLK) disable iff (!RSTN)
      (s_r.abort_on_request_enable && IRQ_LINES[s_r.abort_sel] && s_r.st == dcevt_pkg::DCEVT_RUN)
      |=> s_r.flags[dcevt_pkg::FLAG_ABORT] ##1 s_r.st == dcevt_pkg::DCEVT_IDLE;
  endproperty
  a_abort_irq: assert property (p_abort_irq) else $error("abort irq missed");
  property p_abort_flag;
    @(posedge CLK) disable iff (!RSTN)
      $rose(s_r.flags[dcevt_pkg::FLAG_ABORT]) |-> $past(s_r.abort_on_request_enable) || $past(WR);
  endproperty
  a_abort_flag: assert property (p_abort_flag) else $error("abort flag without cause");
  property p_force;
    @(posedge CLK) disable iff (!RSTN)
      (WR && ADDR == dcevt_pkg::OFS_EVENT_CTRL && WDATA[dcevt_pkg::FORCE_BIT]) |=> s_r.start_p;
  endproperty
  a_force: assert property (p_force) else $error("force write lost");
  property p_swabort;
    @(posedge CLK) disable iff (!RSTN)
      (WR && ADDR == dcevt_pkg::OFS_EVENT_CTRL && WDATA[dcevt_pkg::SWABORT_BIT]
      && s_r.st == dcevt_pkg::DCEVT_RUN) |=> ##1 s_r.st == dcevt_pkg::DCEVT_IDLE;
  endproperty
  a_swabort: assert property (p_swabort) else $error("software abort lost");
  property p_ecr_read;
    @(posedge CLK) disable iff (!RSTN)
      (RD && ADDR == dcevt_pkg::OFS_EVENT_CTRL) |=> RDATA[31:24] == 8'h00 && RDATA[7:6] == 2'b00
      && RDATA[2:0] == 3'b000;
  endproperty
  a_ecr_read: assert property (p_ecr_read) else $error("reserved bits not zero");
  property p_irq;
    @(posedge CLK) disable iff (!RSTN)
      (RD && ADDR == dcevt_pkg::OFS_INT_CTRL) |=> $past(CHAN_IRQ) == |(RDATA[23:16] & RDATA[7:0]);
  endproperty
  a_irq: assert property (p_irq) else $error("irq output mismatch");
  property p_pattern;
    @(posedge CLK) disable iff (!RSTN)
      (s_r.st == dcevt_pkg::DCEVT_RUN && PROG.pattern_match && s_r.pattern_abort_enable && !s_r.abort_p && !WR)
      |=> !s_r.chan_on && s_r.flags[dcevt_pkg::FLAG_BLOCK];
  endproperty
  a_pattern: assert property (p_pattern) else $error("pattern abort failed");
  property p_cell;
    @(posedge CLK) disable iff (!RSTN)
      (s_r.st == dcevt_pkg::DCEVT_RUN && PROG.cell_done) |=> s_r.flags[dcevt_pkg::FLAG_CELL];
  endproperty
  a_cell: assert property (p_cell) else $error("cell flag missed");
  c_start: cover property (@(posedge CLK) disable iff (!RSTN) START_XFER);
  c_abort: cover property (@(posedge CLK) disable iff (!RSTN) ABORT_XFER);
  c_block: cover property (@(posedge CLK) disable iff (!RSTN) $rose(s_r.flags[3]));
  c_abort_flag: cover property (@(posedge CLK) disable iff (!RSTN) $rose(s_r.flags[1]));
  c_irq: cover property (@(posedge CLK) disable iff (!RSTN) $rose(CHAN_IRQ));
  // ========================================
  // register access and event checks
  property p_abort_sel_wr;
    @(posedge CLK) disable iff (!RSTN)
      (WR && ADDR == dcevt_pkg::OFS_EVENT_CTRL)
      |=> s_r.abort_sel == $past(WDATA[dcevt_pkg::ABORT_SEL_LSB +: 8]);
  endproperty
  a_abort_sel_wr: assert property (p_abort_sel_wr) else $error("abort sel lost");
  property p_abort_mover;
    @(posedge CLK) disable iff (!RSTN)
      (s_r.st == dcevt_pkg::DCEVT_RUN && abort_irq && !s_r.abort_p && !PROG.src_step
      && !PROG.pattern_match) |=> ABORT_XFER;
  endproperty
  a_abort_mover: assert property (p_abort_mover) else $error("abort not sent");
  property p_start_sel_wr;
    @(posedge CLK) disable iff (!RSTN)
      (WR && ADDR == dcevt_pkg::OFS_EVENT_CTRL)
      |=> s_r.start_sel == $past(WDATA[dcevt_pkg::START_SEL_LSB +: 8]);
  endproperty
  a_start_sel_wr: assert property (p_start_sel_wr) else $error("start sel lost");
  property p_start_irq;
    @(posedge CLK) disable iff (!RSTN)
      start_irq |=> s_r.start_p;
  endproperty
  a_start_irq: assert property (p_start_irq) else $error("start irq lost");
  property p_force_start;
    @(posedge CLK) disable iff (!RSTN)
      (WR && ADDR == dcevt_pkg::OFS_EVENT_CTRL && WDATA[dcevt_pkg::FORCE_BIT]
      && s_r.st == dcevt_pkg::DCEVT_IDLE && s_r.chan_on && !s_r.start_p) |=> START_XFER;
  endproperty
  a_force_start: assert property (p_force_start) else $error("force no start");
  property p_swabort_out;
    @(posedge CLK) disable iff (!RSTN)
      (WR && ADDR == dcevt_pkg::OFS_EVENT_CTRL && WDATA[dcevt_pkg::SWABORT_BIT] && !s_r.abort_p
      && s_r.st == dcevt_pkg::DCEVT_RUN && !PROG.src_step && !PROG.pattern_match) |=> ABORT_XFER;
  endproperty
  a_swabort_out: assert property (p_swabort_out) else $error("abort no pulse");
  property p_pattern_abort_enable_off;
    @(posedge CLK) disable iff (!RSTN)
      (s_r.st == dcevt_pkg::DCEVT_RUN && PROG.pattern_match && !s_r.pattern_abort_enable && !s_r.abort_p
      && !PROG.src_step) |=> s_r.st == dcevt_pkg::DCEVT_RUN;
  endproperty
  a_pattern_abort_enable_off: assert property (p_pattern_abort_enable_off) else $error("match not ignored");
  property p_start_off;
    @(posedge CLK) disable iff (!RSTN)
      (!s_r.start_on_request_enable && s_r.st == dcevt_pkg::DCEVT_IDLE && !WR && !s_r.start_p)
      |=> s_r.st == dcevt_pkg::DCEVT_IDLE;
  endproperty
  a_start_off: assert property (p_start_off) else $error("idle left");
  property p_abort_off;
    @(posedge CLK) disable iff (!RSTN)
      (!s_r.abort_on_request_enable && !WR && !s_r.flags[1]) |=> !s_r.flags[1];
  endproperty
  a_abort_off: assert property (p_abort_off) else $error("abort irq not ignored");
  property p_int_read;
    @(posedge CLK) disable iff (!RSTN)
      (RD && ADDR == dcevt_pkg::OFS_INT_CTRL) |=> RDATA[31:24] == 8'h00 && RDATA[15:8] == 8'h00;
  endproperty
  a_int_read: assert property (p_int_read) else $error("int reserved set");
  property p_unmapped;
    @(posedge CLK) disable iff (!RSTN)
      (RD && ADDR > dcevt_pkg::OFS_SIZES) |=> RDATA == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_rdata_idle;
    @(posedge CLK) disable iff (!RSTN)
      !RD |=> RDATA == 32'h00000000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data stuck");
  property p_ie_wr;
    @(posedge CLK) disable iff (!RSTN)
      (WR && ADDR == dcevt_pkg::OFS_INT_CTRL) |=> s_r.ie == $past(WDATA[dcevt_pkg::IE_LSB +: 8]);
  endproperty
  a_ie_wr: assert property (p_ie_wr) else $error("enables lost");
  property p_src_done;
    @(posedge CLK) disable iff (!RSTN)
      (s_r.st == dcevt_pkg::DCEVT_RUN && PROG.src_step && {1'b0, PROG.src_ptr} == src_bytes)
      |=> s_r.flags[7];
  endproperty
  a_src_done: assert property (p_src_done) else $error("src done missed");
  property p_src_half;
    @(posedge CLK) disable iff (!RSTN)
      (s_r.st == dcevt_pkg::DCEVT_RUN && PROG.src_step && {1'b0, PROG.src_ptr} == src_bytes >> 1)
      |=> s_r.flags[6];
  endproperty
  a_src_half: assert property (p_src_half) else $error("src half missed");
  property p_dst_done;
    @(posedge CLK) disable iff (!RSTN)
      (s_r.st == dcevt_pkg::DCEVT_RUN && PROG.dst_step && {1'b0, PROG.dst_ptr} == dst_bytes)
      |=> s_r.flags[5];
  endproperty
  a_dst_done: assert property (p_dst_done) else $error("dst done missed");
  property p_dst_half;
    @(posedge CLK) disable iff (!RSTN)
      (s_r.st == dcevt_pkg::DCEVT_RUN && PROG.dst_step && {1'b0, PROG.dst_ptr} == dst_bytes >> 1)
      |=> s_r.flags[4];
  endproperty
  a_dst_half: assert property (p_dst_half) else $error("dst half missed");
  property p_block;
    @(posedge CLK) disable iff (!RSTN)
      (s_r.st == dcevt_pkg::DCEVT_RUN && PROG.src_step && moved_r + 17'h00001 == big_bytes)
      |=> s_r.flags[3];
  endproperty
  a_block: assert property (p_block) else $error("block done missed");
  property p_cell_idle;
    @(posedge CLK) disable iff (!RSTN)
      (s_r.st == dcevt_pkg::DCEVT_IDLE && !WR && !s_r.flags[2]) |=> !s_r.flags[2];
  endproperty
  a_cell_idle: assert property (p_cell_idle) else $error("cell flag idle");
  property p_abort_idle;
    @(posedge CLK) disable iff (!RSTN)
      (s_r.st == dcevt_pkg::DCEVT_IDLE && !WR && !s_r.flags[1]) |=> !s_r.flags[1];
  endproperty
  a_abort_idle: assert property (p_abort_idle) else $error("abort flag idle");
  property p_addr_err;
    @(posedge CLK) disable iff (!RSTN)
      PROG.addr_error |=> s_r.flags[0];
  endproperty
  a_addr_err: assert property (p_addr_err) else $error("addr error missed");
  property p_block_off;
    @(posedge CLK) disable iff (!RSTN)
      (s_r.st == dcevt_pkg::DCEVT_RUN && PROG.src_step && moved_r + 17'h00001 == big_bytes
      && !s_r.abort_p && !s_r.auto_reen) |=> !s_r.chan_on;
  endproperty
  a_block_off: assert property (p_block_off) else $error("channel left on");
  property p_block_auto;
    @(posedge CLK) disable iff (!RSTN)
      (s_r.st == dcevt_pkg::DCEVT_RUN && PROG.src_step && moved_r + 17'h00001 == big_bytes && !WR
      && s_r.auto_reen && s_r.chan_on && !(PROG.pattern_match && s_r.pattern_abort_enable)) |=> s_r.chan_on;
  endproperty
  a_block_auto: assert property (p_block_auto) else $error("auto on lost");
endmodule

// file: testbench/dcevt_mover_model.sv
// dcevt_mover_model: behavioural data mover feeding progress to the channel
// assumes one step per cycle, or one per two cycles while SLOW
`timescale 1ns/1ps
module dcevt_mover_model (
  // clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // channel side
  input wire logic START_XFER,
  input wire logic ABORT_XFER,
  output dcevt_pkg::dcevt_prog_type PROG,
  output logic BUSY,
  // bench control
  input wire logic [15:0] LEN,
  input wire logic SLOW,
  input wire logic MATCH,
  input wire logic BAD_ADDR
);
  logic [15:0] cnt_r;
  logic run_r;
  logic tick_r;
  assign BUSY = run_r;
  always_ff @(posedge CLK) begin
    // pointers carry no meaning between steps
    PROG <= '{src_ptr: ~cnt_r, dst_ptr: ~cnt_r, default: 1'b0};
    PROG.pattern_match <= MATCH;
    PROG.addr_error <= BAD_ADDR;
    tick_r <= ~tick_r & SLOW;
    if (!RSTN) begin
      run_r <= 1'b0;
      cnt_r <= 16'h0000;
      tick_r <= 1'b0;
    end else if (!run_r) begin
      run_r <= START_XFER;
      cnt_r <= 16'h0000;
    end else if (ABORT_XFER || cnt_r == LEN) begin
      run_r <= 1'b0;
    end else if (!tick_r) begin
      cnt_r <= cnt_r + 16'h0001;
      PROG.src_ptr <= cnt_r + 16'h0001;
      PROG.dst_ptr <= cnt_r + 16'h0001;
      PROG.src_step <= 1'b1;
      PROG.dst_step <= 1'b1;
      PROG.cell_done <= (cnt_r[1:0] == 2'h3);
    end
  end
endmodule

// file: testbench/dcevt_channel_test.sv
// dcevt_channel_test: register-level tests of the channel event block
// assumes sizes of 8 bytes and a cell of 4 bytes in the mover model
`timescale 1ns/1ps
module dcevt_channel_test;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic we = 1'b0;
  logic re = 1'b0;
  logic slow = 1'b0;
  logic match = 1'b0;
  logic bad = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [255:0] irq = '0;
  logic [31:0] rdata;
  logic start_x, abort_x, chan_on, chan_irq, busy;
  dcevt_pkg::dcevt_prog_type prog;
  int bad_count = 0;
  int tests_run = 0;
  int starts = 0;
  int s0;
  dcevt_channel dcevt_channel_inst (.CLK(clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata),
    .WR(we), .RD(re), .RDATA(rdata), .IRQ_LINES(irq), .PROG(prog), .START_XFER(start_x),
    .ABORT_XFER(abort_x), .CHAN_ON(chan_on), .CHAN_IRQ(chan_irq));
  dcevt_mover_model dcevt_mover_model_inst (.CLK(clk), .RSTN(rstn), .START_XFER(start_x),
    .ABORT_XFER(abort_x), .PROG(prog), .BUSY(busy), .LEN(16'h0008), .SLOW(slow),
    .MATCH(match), .BAD_ADDR(bad));
  always #50 clk = ~clk;
  always @(negedge clk) if (start_x === 1'b1) starts++;
  // ========================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
    @(posedge clk);
  endtask
  task automatic read_reg(input logic [7:0] a, input logic [31:0] e,
                          input logic [31:0] m = 32'hffffffff);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    @(negedge clk);
    chk(rdata & m, e);
    @(posedge clk);
  endtask
  task automatic chk_pin(input logic got, input logic e);
    @(negedge clk);
    chk({31'h0, got}, {31'h0, e});
    @(posedge clk);
  endtask
  task automatic pulse(input int n);
    irq[n] <= 1'b1;
    @(posedge clk);
    irq[n] <= 1'b0;
  endtask
  task automatic mid;
    for (int i = 0; i < 200 && busy !== 1'b1; i++) @(posedge clk);
    repeat (3) @(posedge clk);
  endtask
  task automatic wait_done;
    mid;
    for (int i = 0; i < 200 && busy !== 1'b0; i++) @(posedge clk);
    repeat (3) @(posedge clk);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ========================================
  // tests
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    read_reg(8'h00, 32'h00ffff00);
    read_reg(8'h04, 32'h0);
    read_reg(8'h40, 32'h0);
    write_reg(8'h00, 32'hffffff38);
    read_reg(8'h00, 32'h00ffff38);
    write_reg(8'h08, 32'h12345678);
    read_reg(8'h08, 32'h12345678);
    write_reg(8'h04, 32'hffff0000);
    read_reg(8'h04, 32'h00ff0000);
    write_reg(8'h10, 32'h00080008);
    write_reg(8'h0c, 32'h00000080);
    write_reg(8'h00, 32'h0000ff80);
    wait_done;
    read_reg(8'h04, 32'h00ff00fc);
    read_reg(8'h00, 32'h0000ff00);
    chk_pin(chan_on, 1'b0);
    chk_pin(chan_irq, 1'b1);
    write_reg(8'h04, 32'h000000fc);
    chk_pin(chan_irq, 1'b0);
    write_reg(8'h04, 32'h000800fc);
    chk_pin(chan_irq, 1'b1);
    write_reg(8'h04, 32'h00ff0000);
    chk_pin(chan_irq, 1'b0);
    write_reg(8'h0c, 32'h00000090);
    write_reg(8'h00, 32'h00050308);
    s0 = starts;
    pulse(3);
    repeat (5) @(posedge clk);
    chk(starts, s0);
    write_reg(8'h00, 32'h00050310);
    slow <= 1'b1;
    pulse(3);
    mid;
    pulse(5);
    wait_done;
    read_reg(8'h04, 32'h08, 32'h0a);
    chk_pin(chan_on, 1'b1);
    write_reg(8'h04, 32'h00ff0000);
    write_reg(8'h00, 32'h00050318);
    pulse(3);
    mid;
    pulse(5);
    wait_done;
    read_reg(8'h04, 32'h02, 32'h0a);
    write_reg(8'h04, 32'h00ff0000);
    write_reg(8'h0c, 32'h00000080);
    write_reg(8'h00, 32'h00000080);
    mid;
    write_reg(8'h00, 32'h00000040);
    wait_done;
    read_reg(8'h04, 32'h0, 32'h0a);
    write_reg(8'h0c, 32'h00000080);
    write_reg(8'h00, 32'h000000a0);
    mid;
    match <= 1'b1;
    @(posedge clk);
    match <= 1'b0;
    wait_done;
    read_reg(8'h04, 32'h08, 32'h08);
    chk_pin(chan_on, 1'b0);
    write_reg(8'h04, 32'h00ff0000);
    bad <= 1'b1;
    @(posedge clk);
    bad <= 1'b0;
    repeat (3) @(posedge clk);
    read_reg(8'h04, 32'h01, 32'h01);
    chk_pin(chan_irq, 1'b1);
    end_of_test;
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    end_of_test;
  end
endmodule
